// file: design/mfs_pkg.sv
// Package of constants for the supervisor; assumes a 125 MHz system clock.
package mfs_pkg;
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned SEC_CYCLES = CLK_HZ;
	localparam int unsigned EXT_FAULT_S = 2;
	localparam int unsigned EXT_FAULT_CYCLES = EXT_FAULT_S * CLK_HZ;
	localparam logic [11:0] INS_CLEAR_S = 12'h03C;
	localparam logic [11:0] SLOW_MAX_S = 12'h01E;
	localparam logic [11:0] SHEAR_X85 = 12'h352;
	localparam logic [7:0] HEATSINK_MAX_C = 8'h55;
	localparam logic [11:0] SEC_PER_MIN = 12'h03C;
	// Word indices on the bus (byte address = 4 * index)
	localparam logic [2:0] IDX_CTRL = 3'h0;
	localparam logic [2:0] IDX_START = 3'h1;
	localparam logic [2:0] IDX_SHEAR = 3'h2;
	localparam logic [2:0] IDX_UC = 3'h3;
	localparam logic [2:0] IDX_VOLT = 3'h4;
	localparam logic [2:0] IDX_OL = 3'h5;
	localparam logic [2:0] IDX_STATUS = 3'h6;
	localparam int unsigned NCFG = 6;
	localparam logic [31:0] CFG_RST [NCFG] = '{32'h0000_0000, 32'h000A_1E0A, 32'h0000_0352,
		32'h0000_0A14, 32'h0005_6E55, 32'h0000_0073};
	localparam logic [31:0] CFG_MASK [NCFG] = '{32'h0000_000E, 32'h001F_3F0F, 32'h0007_03FF,
		32'h0000_FF7F, 32'h00FF_FFFF, 32'h0000_03FF};
	// Field positions
	localparam int unsigned CTRL_CLR_B = 0;
	localparam int unsigned CTRL_GEN_B = 1;
	localparam int unsigned CTRL_INS_B = 2;
	localparam int unsigned CTRL_THM_B = 3;
	localparam int unsigned ST_MAX_L = 0;
	localparam int unsigned ST_PER_L = 8;
	localparam int unsigned ST_TIME_L = 16;
	localparam int unsigned SH_DLY_L = 16;
	localparam int unsigned UC_DLY_L = 8;
	localparam int unsigned V_OV_L = 8;
	localparam int unsigned V_DLY_L = 16;
	typedef enum logic [4:0] {
		MSG_NONE = 5'h00, MSG_INSUL = 5'h01, MSG_THERM = 5'h02, MSG_STARTS = 5'h03,
		MSG_LONG_START = 5'h04, MSG_SHEAR = 5'h05, MSG_OVERLOAD = 5'h06, MSG_UNDERCUR = 5'h07,
		MSG_UNDERVOLT = 5'h08, MSG_OVERVOLT = 5'h09, MSG_PHASE_LOSS = 5'h0A, MSG_PHASE_SEQ = 5'h0B,
		MSG_SLOW_SPEED = 5'h0C, MSG_WRONG_CONN = 5'h0D, MSG_SHORT_SCR = 5'h0E, MSG_OVERTEMP = 5'h0F,
		MSG_EXT_FAULT = 5'h10, MSG_WRONG_PARAM = 5'h11, MSG_ALARM_INSUL = 5'h12
	} mfs_msg_t;
endpackage

// file: design/mfs_supervisor.sv
// Fault and alarm supervisor of a motor soft starter, Wishbone classic slave.
// Assumes measurement values come from on-chip logic on clk_i; flag pins are asynchronous.
//
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
module mfs_supervisor
	import mfs_pkg::*;
#(
	parameter int unsigned SEC_CYC = SEC_CYCLES,
	parameter int unsigned EXT_CYC = EXT_FAULT_CYCLES
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [11:0] cur_motor_pct_i,
	input wire logic [11:0] cur_starter_pct_i,
	input wire logic [7:0] line_volt_pct_i,
	input wire logic [7:0] heatsink_temp_c_i,
	input wire logic phase_loss_i,
	input wire logic phase_seq_bad_i,
	input wire logic wrong_conn_i,
	input wire logic shorted_scr_i,
	input wire logic ext_contact_i,
	input wire logic insul_below_alarm_i,
	input wire logic insul_below_trip_i,
	input wire logic thermistor_low_i,
	input wire logic slow_speed_i,
	input wire logic volt_nominal_i,
	input wire logic starting_i,
	input wire logic running_i,
	input wire logic thermal_full_i,
	input wire logic nv_xfer_fail_i,
	output logic motor_en_o,
	output logic start_block_o,
	output logic fault_led_o,
	output logic fault_relay_o,
	output logic alarm_relay_o,
	output logic [4:0] msg_sel_o
);
	logic [13:0] sync1_q;
	logic [13:0] sync2_q;
	logic s_phl, s_seq, s_wc, s_scr, s_ext, s_ins_a, s_ins_t, s_thm;
	logic s_slow, s_vnom, s_start, s_run, s_thfull, s_nvf;
	logic [31:0] cfg_q [NCFG];
	logic clr_q;
	logic [31:0] div_q;
	logic tick_q;
	logic blink_q;
	logic start_d1_q;
	logic [3:0] start_cnt_q;
	logic [11:0] win_q;
	logic [11:0] ls_q, sh_q, uc_q, uv_q, ov_q, slow_q, ins_q;
	logic [31:0] ext_q;
	logic ins_alarm_q;
	logic trip_q;
	mfs_msg_t code_q;
	mfs_msg_t code_d;
	logic any_trip;
	logic gen, opt_ins, opt_thm;
	logic t_ins, t_thm, t_starts, t_long, t_shear, t_ol, t_uc, t_uv, t_ov, t_slow;
	logic t_wc, t_scr, t_temp, t_ext;
	logic shear_inst, shear_det;
	logic bus_req;
	logic [2:0] idx;

	// Pins cross into clk_i; first stage only feeds the second
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync1_q <= 14'h0000;
			sync2_q <= 14'h0000;
		end
		else if (ce_i)
		begin
			sync1_q <= {phase_loss_i, phase_seq_bad_i, wrong_conn_i, shorted_scr_i, ext_contact_i,
				insul_below_alarm_i, insul_below_trip_i, thermistor_low_i, slow_speed_i,
				volt_nominal_i, starting_i, running_i, thermal_full_i, nv_xfer_fail_i};
			sync2_q <= sync1_q;
		end
	end
	assign {s_phl, s_seq, s_wc, s_scr, s_ext, s_ins_a, s_ins_t, s_thm, s_slow, s_vnom, s_start,
		s_run, s_thfull, s_nvf} = sync2_q;

	function automatic logic [11:0] mfs_tcount(input logic [11:0] c, input logic en, input logic tk);
		if (!en)
			return 12'h000;
		else if (tk && c != 12'hFFF)
			return c + 12'h001;
		else
			return c;
	endfunction

	// Wishbone slave: one wait state, ack for one cycle
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign idx = wb_adr_i[4:2];
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			clr_q <= 1'b0;
			for (int i = 0; i < NCFG; i++)
				cfg_q[i] <= CFG_RST[i];
		end
		else if (ce_i)
		begin
			wb_ack_o <= bus_req;
			clr_q <= bus_req && wb_we_i && idx == IDX_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_CLR_B];
			wb_dat_o <= 32'h0000_0000;
			if (bus_req && wb_we_i && wb_adr_i[7:5] == 3'h0 && idx < IDX_STATUS)
			begin
				for (int b = 0; b < 4; b++)
					if (wb_sel_i[b])
						cfg_q[idx][8*b +: 8] <= wb_dat_i[8*b +: 8] & CFG_MASK[idx][8*b +: 8];
			end
			else if (bus_req && !wb_we_i && wb_adr_i[7:5] == 3'h0 && idx < IDX_STATUS)
				wb_dat_o <= cfg_q[idx];
			else if (bus_req && !wb_we_i && wb_adr_i[7:5] == 3'h0 && idx == IDX_STATUS)
				wb_dat_o <= {25'h0000000, ins_alarm_q, trip_q, code_q};
		end
	end

	assign gen = cfg_q[IDX_CTRL][CTRL_GEN_B];
	assign opt_ins = cfg_q[IDX_CTRL][CTRL_INS_B];
	assign opt_thm = cfg_q[IDX_CTRL][CTRL_THM_B];

	// One-second time base; seconds resolution is plenty for protection delays
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			div_q <= 32'h0000_0000;
			tick_q <= 1'b0;
			blink_q <= 1'b0;
		end
		else if (ce_i)
		begin
			tick_q <= 1'b0;
			if (div_q >= SEC_CYC - 1)
			begin
				div_q <= 32'h0000_0000;
				tick_q <= 1'b1;
				blink_q <= !blink_q;
			end
			else
				div_q <= div_q + 32'h0000_0001;
		end
	end

	// Start counting within the start period
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			start_d1_q <= 1'b0;
			start_cnt_q <= 4'h0;
			win_q <= 12'h000;
		end
		else if (ce_i)
		begin
			start_d1_q <= s_start;
			if (start_cnt_q != 4'h0 && tick_q &&
				win_q + 12'h001 >= 12'(cfg_q[IDX_START][ST_PER_L +: 6]) * SEC_PER_MIN)
			begin
				start_cnt_q <= {3'h0, s_start && !start_d1_q};
				win_q <= 12'h000;
			end
			else
			begin
				if (s_start && !start_d1_q && start_cnt_q != 4'hF)
					start_cnt_q <= start_cnt_q + 4'h1;
				if (start_cnt_q != 4'h0 && tick_q)
					win_q <= win_q + 12'h001;
			end
		end
	end
	assign t_starts = start_cnt_q > cfg_q[IDX_START][ST_MAX_L +: 4];

	// Shear-pin detection
	assign shear_inst = cur_starter_pct_i >= SHEAR_X85;
	assign shear_det = cur_starter_pct_i > SHEAR_X85 || (s_start && cur_motor_pct_i > SHEAR_X85) ||
		(s_run && cur_motor_pct_i > cfg_q[IDX_SHEAR][11:0]);

	// Delay counters in seconds, reset as soon as the condition drops
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ls_q <= 12'h000;
			sh_q <= 12'h000;
			uc_q <= 12'h000;
			uv_q <= 12'h000;
			ov_q <= 12'h000;
			slow_q <= 12'h000;
		end
		else if (ce_i)
		begin
			ls_q <= mfs_tcount(ls_q, s_start && !s_vnom, tick_q);
			sh_q <= mfs_tcount(sh_q, shear_det, tick_q);
			uc_q <= mfs_tcount(uc_q, s_run && cur_motor_pct_i < {5'h00, cfg_q[IDX_UC][6:0]}, tick_q);
			uv_q <= mfs_tcount(uv_q, line_volt_pct_i < cfg_q[IDX_VOLT][7:0], tick_q);
			ov_q <= mfs_tcount(ov_q, line_volt_pct_i > cfg_q[IDX_VOLT][V_OV_L +: 8], tick_q);
			slow_q <= mfs_tcount(slow_q, s_slow, tick_q);
		end
	end

	// External contact counted in cycles for an exact two-second bound
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ext_q <= 32'h0000_0000;
		else if (ce_i)
		begin
			if (!s_ext)
				ext_q <= 32'h0000_0000;
			else if (ext_q <= EXT_CYC)
				ext_q <= ext_q + 32'h0000_0001;
		end
	end

	assign t_ins = opt_ins && s_ins_t;
	assign t_thm = opt_thm && s_thm;
	assign t_long = s_start && !s_vnom && ls_q >= {7'h00, cfg_q[IDX_START][ST_TIME_L +: 5]};
	assign t_shear = shear_inst || (shear_det && sh_q >= {9'h000, cfg_q[IDX_SHEAR][SH_DLY_L +: 3]});
	assign t_ol = cur_motor_pct_i > cfg_q[IDX_OL][11:0] && s_thfull;
	assign t_uc = s_run && cur_motor_pct_i < {5'h00, cfg_q[IDX_UC][6:0]} &&
		uc_q >= {4'h0, cfg_q[IDX_UC][UC_DLY_L +: 8]};
	assign t_uv = line_volt_pct_i == 8'h00 || (line_volt_pct_i < cfg_q[IDX_VOLT][7:0] &&
		uv_q >= {4'h0, cfg_q[IDX_VOLT][V_DLY_L +: 8]});
	assign t_ov = line_volt_pct_i > cfg_q[IDX_VOLT][V_OV_L +: 8] &&
		ov_q >= {4'h0, cfg_q[IDX_VOLT][V_DLY_L +: 8]};
	assign t_slow = s_slow && slow_q > SLOW_MAX_S;
	assign t_wc = !gen && s_wc;
	assign t_scr = !gen && s_scr;
	assign t_temp = heatsink_temp_c_i > HEATSINK_MAX_C;
	assign t_ext = ext_q > EXT_CYC;

	// Fixed priority when several faults appear together
	always_comb
	begin
		code_d = MSG_NONE;
		if (s_nvf)
			code_d = MSG_WRONG_PARAM;
		else if (t_scr)
			code_d = MSG_SHORT_SCR;
		else if (t_wc)
			code_d = MSG_WRONG_CONN;
		else if (s_phl)
			code_d = MSG_PHASE_LOSS;
		else if (s_seq)
			code_d = MSG_PHASE_SEQ;
		else if (t_shear)
			code_d = MSG_SHEAR;
		else if (t_uv)
			code_d = MSG_UNDERVOLT;
		else if (t_ov)
			code_d = MSG_OVERVOLT;
		else if (t_temp)
			code_d = MSG_OVERTEMP;
		else if (t_ins)
			code_d = MSG_INSUL;
		else if (t_thm)
			code_d = MSG_THERM;
		else if (t_ol)
			code_d = MSG_OVERLOAD;
		else if (t_long)
			code_d = MSG_LONG_START;
		else if (t_starts)
			code_d = MSG_STARTS;
		else if (t_uc)
			code_d = MSG_UNDERCUR;
		else if (t_slow)
			code_d = MSG_SLOW_SPEED;
		else if (t_ext)
			code_d = MSG_EXT_FAULT;
	end
	assign any_trip = code_d != MSG_NONE;

	// Trip latch; a reset command is ignored while any fault persists
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			trip_q <= 1'b0;
			code_q <= MSG_NONE;
		end
		else if (ce_i)
		begin
			if (!trip_q && any_trip)
			begin
				trip_q <= 1'b1;
				code_q <= code_d;
			end
			else if (trip_q && clr_q && !any_trip)
			begin
				trip_q <= 1'b0;
				code_q <= MSG_NONE;
			end
		end
	end

	// Insulation alarm with self-clearing hold-off
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ins_alarm_q <= 1'b0;
			ins_q <= 12'h000;
		end
		else if (ce_i)
		begin
			ins_q <= mfs_tcount(ins_q, ins_alarm_q && !s_ins_a, tick_q);
			if (opt_ins && s_ins_a)
				ins_alarm_q <= 1'b1;
			else if (ins_q >= INS_CLEAR_S)
				ins_alarm_q <= 1'b0;
		end
	end

	// Registered outputs
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			motor_en_o <= 1'b0;
			start_block_o <= 1'b1;
			fault_led_o <= 1'b0;
			fault_relay_o <= 1'b0;
			alarm_relay_o <= 1'b0;
			msg_sel_o <= MSG_NONE;
		end
		else if (ce_i)
		begin
			motor_en_o <= !trip_q;
			start_block_o <= trip_q || t_wc || t_scr;
			fault_relay_o <= trip_q;
			alarm_relay_o <= ins_alarm_q;
			if (trip_q)
			begin
				fault_led_o <= 1'b1;
				msg_sel_o <= code_q;
			end
			else if (ins_alarm_q)
			begin
				fault_led_o <= blink_q;
				msg_sel_o <= MSG_ALARM_INSUL;
			end
			else
			begin
				fault_led_o <= 1'b0;
				msg_sel_o <= MSG_NONE;
			end
		end
	end

	a_trip_stops_motor: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && trip_q |=> !motor_en_o && fault_relay_o) else $error("trip did not stop motor");
	a_alarm_keeps_run: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && ins_alarm_q && !trip_q |=> motor_en_o && alarm_relay_o && msg_sel_o == MSG_ALARM_INSUL)
		else $error("alarm handling wrong");
	a_zero_volt_trip: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && line_volt_pct_i == 8'h00 |=> trip_q) else $error("zero voltage did not trip");
	a_shear_instant: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && cur_starter_pct_i >= SHEAR_X85 |=> trip_q) else $error("shear pin not immediate");
	a_overtemp_trip: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && heatsink_temp_c_i > HEATSINK_MAX_C && !trip_q |=> trip_q && code_q != MSG_NONE)
		else $error("over temperature did not trip");
	a_gen_mask: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && gen && !trip_q |=> !(code_q == MSG_SHORT_SCR || code_q == MSG_WRONG_CONN))
		else $error("generator mode mask failed");
	a_trip_latched: assert property (@(posedge clk_i) disable iff (rst_i)
		trip_q && !(ce_i && clr_q && !any_trip) |=> trip_q) else $error("trip released early");
	a_ext_two_sec: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !trip_q && code_d == MSG_EXT_FAULT |-> ext_q > EXT_CYC && s_ext)
		else $error("external fault before two seconds");
	a_scr_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !gen && s_scr |=> start_block_o && trip_q) else $error("shorted thyristor not blocked");
endmodule // mfs_supervisor

// file: test/mfs_front_model.sv
// Front-end model: measured values and status flags as the motor side presents them.
// Assumes the bench selects one fault at a time by its message code on fault_i.
`timescale 1ns/100ps
module mfs_front_model
(
	input wire logic clk_i,
	input wire logic [4:0] fault_i,
	input wire logic [4:0] jitter_i,
	input wire logic motor_en_i,
	output logic [11:0] cur_mot_o,
	output logic [11:0] cur_st_o,
	output logic [7:0] volt_o,
	output logic [7:0] temp_o,
	output logic ploss_o,
	output logic pseq_o,
	output logic wconn_o,
	output logic sscr_o,
	output logic ext_o,
	output logic ins_al_o,
	output logic ins_tr_o,
	output logic therm_o,
	output logic slow_o,
	output logic nom_o,
	output logic start_o,
	output logic run_o,
	output logic tfull_o,
	output logic nvf_o
);
	logic [1:0] cnt_q = 2'h0;
	always_ff @(posedge clk_i)
	begin
		cnt_q <= cnt_q + 2'h1;
	end
	always_comb
	begin
		cur_mot_o = (fault_i == 5'h06) ? 12'h0C8 : (fault_i == 5'h07) ? 12'h005 : 12'h050 + {7'h00, jitter_i};
		cur_st_o = (fault_i == 5'h05) ? 12'h353 : (fault_i == 5'h07) ? 12'h003 : 12'h040;
		volt_o = (fault_i == 5'h08) ? 8'h00 : (fault_i == 5'h09) ? 8'h78 : 8'h64;
		temp_o = (fault_i == 5'h0F) ? 8'h56 : 8'h28;
		ploss_o = (fault_i == 5'h0A);
		pseq_o = (fault_i == 5'h0B);
		wconn_o = (fault_i == 5'h0D);
		sscr_o = (fault_i == 5'h0E);
		ext_o = (fault_i == 5'h10);
		ins_al_o = (fault_i == 5'h12);
		ins_tr_o = (fault_i == 5'h01);
		therm_o = (fault_i == 5'h02);
		slow_o = (fault_i == 5'h0C);
		nom_o = (fault_i != 5'h04);
		tfull_o = (fault_i == 5'h06);
		nvf_o = (fault_i == 5'h11);
		// Short start pulses, so repeated starts come quickly
		start_o = (fault_i == 5'h04) | ((fault_i == 5'h03) & cnt_q[1]);
		run_o = (motor_en_i === 1'b1) & ~start_o; // Motor turns only while allowed
	end
endmodule // mfs_front_model

// file: test/motor_starter_fault_supervisor_tb.sv
// Bench for the supervisor: faults come through the front-end model, registers over Wishbone.
// Assumes shortened second and contact counts so that timed trips fit a short run.
`timescale 1ns/100ps
module motor_starter_fault_supervisor_tb;
	import mfs_pkg::*;
	localparam int unsigned SC = 10;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
	logic wb_ack_o, motor_en_o, start_block_o, fault_led_o, fault_relay_o, alarm_relay_o, led;
	logic [4:0] msg_sel_o, fault = 5'h00, jitter = 5'h00;
	logic [11:0] cur_motor_pct_i, cur_starter_pct_i;
	logic [7:0] line_volt_pct_i, heatsink_temp_c_i;
	logic phase_loss_i, phase_seq_bad_i, wrong_conn_i, shorted_scr_i, ext_contact_i, insul_below_alarm_i;
	logic insul_below_trip_i, thermistor_low_i, slow_speed_i, volt_nominal_i, starting_i, running_i;
	logic thermal_full_i, nv_xfer_fail_i;
	logic [31:0] seed = 32'h0000_B318;
	int bad_count = 0, n_compared = 0;
	// Fault code and shortest trip time in cycles (one second of tick slack)
	logic [4:0] codes [17] = '{5'h03, 5'h11, 5'h0E, 5'h0D, 5'h0A, 5'h0B, 5'h08, 5'h0F, 5'h05, 5'h06, 5'h09,
		5'h07, 5'h0C, 5'h10, 5'h04, 5'h01, 5'h02};
	int mins [17] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 40, 90, 300, 20, 90, 0, 0};

	always #4 clk_i = ~clk_i;

	mfs_supervisor #(.SEC_CYC(SC), .EXT_CYC(20)) i_mfs_supervisor (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cur_motor_pct_i, .cur_starter_pct_i,
		.line_volt_pct_i, .heatsink_temp_c_i, .phase_loss_i, .phase_seq_bad_i, .wrong_conn_i, .shorted_scr_i,
		.ext_contact_i, .insul_below_alarm_i, .insul_below_trip_i, .thermistor_low_i, .slow_speed_i, .volt_nominal_i,
		.starting_i, .running_i, .thermal_full_i, .nv_xfer_fail_i, .motor_en_o, .start_block_o, .fault_led_o,
		.fault_relay_o, .alarm_relay_o, .msg_sel_o);

	mfs_front_model i_mfs_front_model (.clk_i, .fault_i(fault), .jitter_i(jitter), .motor_en_i(motor_en_o),
		.cur_mot_o(cur_motor_pct_i), .cur_st_o(cur_starter_pct_i), .volt_o(line_volt_pct_i),
		.temp_o(heatsink_temp_c_i), .ploss_o(phase_loss_i), .pseq_o(phase_seq_bad_i), .wconn_o(wrong_conn_i),
		.sscr_o(shorted_scr_i), .ext_o(ext_contact_i), .ins_al_o(insul_below_alarm_i),
		.ins_tr_o(insul_below_trip_i), .therm_o(thermistor_low_i), .slow_o(slow_speed_i), .nom_o(volt_nominal_i),
		.start_o(starting_i), .run_o(running_i), .tfull_o(thermal_full_i), .nvf_o(nv_xfer_fail_i));

	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic test_done;
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic lim(input string what);
		bad_count++;
		$display("ERROR %s expected done seen timeout", what);
		test_done();
	endtask

	// Classic single cycle; the answer time is never assumed
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 20);
		// Judge by ack itself, so an answer on the last allowed edge still counts
		if (wb_ack_o !== 1'b1)
			lim("bus_ack");
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic trip_case(input logic [4:0] c, input int m);
		int n;
		n = 0;
		seed = xs(seed);
		jitter <= seed[4:0];
		fault <= c;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (fault_relay_o !== 1'b1 && n < m + 60);
		if (fault_relay_o !== 1'b1)
			lim("trip_wait");
		check("trip_time", (n >= m) && (n <= m + 20), 1'b1);
		@(posedge clk_i);
		check("trip_out", {motor_en_o, start_block_o, fault_led_o, msg_sel_o}, {3'b011, c});
		wb(1'b0, 8'h18, 32'h0000_0000, 4'hF);
		check("status", rd, {26'h0000000, 1'b1, c});
		if (c != 5'h07)
		begin
			wb(1'b1, 8'h00, 32'h0000_000D, 4'hF);
			repeat (2) @(posedge clk_i);
			check("clr_refused", {fault_relay_o, msg_sel_o}, {1'b1, c});
		end
		fault <= 5'h00;
		repeat ((c == 5'h03) ? 700 : 6) @(posedge clk_i);
		wb(1'b1, 8'h00, 32'h0000_000D, 4'hF);
		repeat (3) @(posedge clk_i);
		check("clr_done", {fault_relay_o, motor_en_o, start_block_o, msg_sel_o}, {3'b010, 5'h00});
		$display("trip test %0d done", c);
	endtask

	initial
	begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 6; i++)
		begin
			wb(1'b0, 8'(i * 4), 32'h0000_0000, 4'hF);
			check("cfg_reset", rd, CFG_RST[i]);
		end
		wb(1'b0, 8'h1C, 32'h0000_0000, 4'hF);
		check("unmapped", rd, 32'h0000_0000);
		wb(1'b1, 8'h18, 32'hFFFF_FFFF, 4'hF);
		wb(1'b0, 8'h18, 32'h0000_0000, 4'hF);
		check("status_ro", rd, 32'h0000_0000);
		wb(1'b1, 8'h14, 32'hFFFF_FFFF, 4'h1);
		wb(1'b0, 8'h14, 32'h0000_0000, 4'hF);
		check("byte_lane", rd, 32'h0000_00FF);
		wb(1'b1, 8'h14, 32'h0000_0073, 4'hF);
		$display("register test done");
		// One start allowed in a one-minute window, then the defaults return
		wb(1'b1, 8'h04, 32'h000A_0101, 4'hF);
		wb(1'b1, 8'h00, 32'h0000_000C, 4'hF);
		for (int i = 0; i < 17; i++)
		begin
			trip_case(codes[i], mins[i]);
			if (i == 0)
				wb(1'b1, 8'h04, 32'h000A_1E0A, 4'hF);
		end
		wb(1'b1, 8'h00, 32'h0000_000E, 4'hF);
		for (int i = 13; i < 15; i++)
		begin
			fault <= 5'(i);
			repeat (20) @(posedge clk_i);
			check("gen_mode", {fault_relay_o, start_block_o}, 2'b00);
		end
		fault <= 5'h00;
		wb(1'b1, 8'h00, 32'h0000_000C, 4'hF);
		$display("generator test done");
		fault <= 5'h12;
		repeat (10) @(posedge clk_i);
		check("alarm", {alarm_relay_o, motor_en_o, fault_relay_o, msg_sel_o}, {3'b110, 5'h12});
		led = fault_led_o;
		repeat (SC) @(posedge clk_i);
		// Logical not keeps the expectation one bit wide in the 32-bit argument
		check("alarm_flash", fault_led_o, !led);
		fault <= 5'h00;
		repeat (500) @(posedge clk_i);
		check("alarm_hold", alarm_relay_o, 1'b1);
		repeat (150) @(posedge clk_i);
		check("alarm_clear", alarm_relay_o, 1'b0);
		$display("alarm test done");
		// Clock enable low must freeze the instant over-temperature trip
		ce_i <= 1'b0;
		fault <= 5'h0F;
		repeat (10) @(posedge clk_i);
		check("ce_frozen", {fault_relay_o, motor_en_o}, 2'b01);
		ce_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		check("ce_resumed", {fault_relay_o, motor_en_o, msg_sel_o}, {2'b10, 5'h0F});
		fault <= 5'h00;
		$display("clock enable test done");
		test_done();
	end
endmodule // motor_starter_fault_supervisor_tb
